// File: design/sensor_spi_lowpower_map.svh
// Constants of the sensor serial slave and low-power controller.
// Assumes a 250 MHz core clock; included by bare name.
`ifndef SENSOR_SPI_LOWPOWER_MAP_SVH
`define SENSOR_SPI_LOWPOWER_MAP_SVH
`define CLOCK_PERIOD_NS 4
`define SLEEP_UNIT_NS 2000000
`define SLEEP_UNIT_CYCLES (`SLEEP_UNIT_NS / `CLOCK_PERIOD_NS)
`define FRAME_BITS 6'd32
`define CMD_BITS 6'd8
`define PAYLOAD_BITS 6'd24
`define CRC_POLY 8'h1D
`define CRC_INIT 8'hFF
`define CRC_XOR 8'hFF
`define CMD_RW_BIT 0
`define CMD_ADDR_LSB 1
`define RC_RESET 4'h0
`define RC_FIRST 4'h1
`define RC_LAST 4'hF
`define ST_RC_LSB 4
`define ST_FAULT_A_BIT 3
`define ST_FAULT_B_BIT 2
`define ST_CRC_ERR_BIT 1
`define ST_FRESH_BIT 0
`define CHAN_ADDR_FIRST 7'h00
`define CHAN_ADDR_LAST 7'h02
`define CMD_CHAN_ADDR 7'h03
`define SLEEP_COMMAND 16'hA55A
`define SB_THR0_LSB 0
`define SB_THR1_LSB 2
`define SB_THR2_LSB 4
`define SB_EDGE_LSB 6
`define SB_TIMER_BIT 8
`define SB_WAKEOUT_BIT 9
`define THR_ABOVE 2'h1
`define THR_BELOW 2'h2
`endif

// File: design/sensor_spi_lowpower_pkg.sv
// Types shared by the sensor serial slave and low-power controller.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package sensor_spi_lowpower_pkg;
   // Phases of the low-power controller.
   typedef enum logic [1:0] {
      RUN_CONT,
      SLEEPING,
      WAKE_INIT,
      AWAKE
   } power_state_t;
   // Width of one measurement or register word.
   typedef logic [15:0] word_t;
   // Channel thresholds and samples, one word per channel.
   typedef logic [2:0][15:0] chan_words_t;
endpackage
`default_nettype wire

// File: design/sensor_spi_slave_lowpower.sv
// Serial slave of a current sensor with its sleep and wake sequencing.
// Assumes the serial pins and the wake pin are asynchronous to clock,
// and that the register file answers a read strobe in the next cycle.
//
// What this block does
// R01: Sensor is slave; master owns clock, select, data.
// R02: Master holds select low through one frame.
// R03: Master frame: command, 16-bit data, CRC.
// R04: Slave frame: status, 16-bit data, CRC.
// R05: Reply to previous command shifts during current.
// R06: CRC-8 poly 1D, seed FF, final XOR FF.
// R07: Each direction carries CRC over own bytes.
// R08: Command holds 7-bit address plus read flag.
// R09: Writes happen only after a good CRC.
// R10: Reads start right after the command byte.
// R11: Every 32-clock frame checked; mismatch flags next status.
// R12: Status: counter, fault A, fault B, CRC, fresh.
// R13: Counter resets zero, runs 1 to 15, wraps.
// R14: Fault bits set when fault register nonzero.
// R15: Fault bits refresh only on channel reads.
// R16: Fresh flag shows an undelivered sample.
// R17: Sleep and active phases chosen by standby bits.
// R18: Pin edge wakes sensor in pin-wake mode.
// R19: Timer wakes sensor and toggles wake pin.
// R20: Threshold mode toggles only when condition holds.
// R21: Combined mode wakes on timer or pin.
// R22: Master gives two wake edges in combined mode.
// R23: Writing A55A to command channel sends sleep.
// R24: Edge select: off, rising, falling, both.
// R25: Threshold select: off, above, below, reserved.
// R26: Sleep lasts (n+1) times two milliseconds.
// R27: MSB first; complete frame is exactly 32 clocks.
// R28: Wake toggle only after first measurement starts.
`include "sensor_spi_lowpower_map.svh"
`default_nettype none
module sensor_spi_slave_lowpower #(
   parameter int unsigned SleepUnitCycles = `SLEEP_UNIT_CYCLES
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic spiClk, // Serial clock from the master.
   input wire logic chipSelectLow, // Frame select, active low.
   input wire logic mosi,
   output logic misoOut,
   output logic misoOe, // High while this slave drives its data line.
   input wire logic wakePinIn,
   output logic wakePinOut,
   output logic wakePinOe, // High while the sensor drives the wake pin.
   input wire logic [9:0] standbyConfig,
   input wire logic [7:0] sleepTimeHigh,
   input wire sensor_spi_lowpower_pkg::word_t faultRegA,
   input wire sensor_spi_lowpower_pkg::word_t faultRegB,
   output logic readStrobe,
   output logic [6:0] readAddr,
   input wire sensor_spi_lowpower_pkg::word_t readData,
   input wire logic readFresh,
   output logic writeStrobe,
   output logic [6:0] writeAddr,
   output sensor_spi_lowpower_pkg::word_t writeData,
   input wire logic initDone,
   input wire logic measStart,
   input wire logic measValid,
   input wire sensor_spi_lowpower_pkg::chan_words_t measValue,
   input wire sensor_spi_lowpower_pkg::chan_words_t thresholdValue,
   output logic activePhase
);
   import sensor_spi_lowpower_pkg::*;

   // Serial CRC step over a whole payload, MSB first.
   function automatic logic [7:0] crcOf(input logic [23:0] payload);
      logic [7:0] crc;
      crc = `CRC_INIT;
      for (int i = 23; i >= 0; i--) begin
         crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ payload[i]) ? `CRC_POLY : 8'h00); // see R06
      end
      return crc ^ `CRC_XOR; // see R06
   endfunction

   // Two-flop synchronisers for the serial and wake pins, plus a third
   // stage that only the edge detectors compare against.
   logic [1:0] sckSync_q, csSync_q, mosiSync_q, wakeSync_q;
   logic sckLast_q, csLast_q, wakeLast_q;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sckSync_q <= 2'h0;
         csSync_q <= 2'h3;
         mosiSync_q <= 2'h0;
         wakeSync_q <= 2'h0;
         sckLast_q <= 1'b0;
         csLast_q <= 1'b1;
         wakeLast_q <= 1'b0;
      end else begin
         sckSync_q <= {sckSync_q[0], spiClk};
         csSync_q <= {csSync_q[0], chipSelectLow};
         mosiSync_q <= {mosiSync_q[0], mosi};
         wakeSync_q <= {wakeSync_q[0], wakePinIn};
         sckLast_q <= sckSync_q[1];
         csLast_q <= csSync_q[1];
         wakeLast_q <= wakeSync_q[1];
      end
   end

   // Edge decode of the synchronised pins.
   wire selected = !csSync_q[1]; // see R02
   wire frameStart = csLast_q && !csSync_q[1];
   wire frameEnd = !csLast_q && csSync_q[1];
   wire sckRise = selected && !sckLast_q && sckSync_q[1]; // see R01
   wire sckFall = selected && sckLast_q && !sckSync_q[1];
   wire wakeRise = !wakeLast_q && wakeSync_q[1];
   wire wakeFall = wakeLast_q && !wakeSync_q[1];

   // Receive side state.
   logic [5:0] bitCount_q; // Rising edges seen in this frame.
   logic [31:0] rxShift_q; // Master frame, MSB first.
   logic [31:0] txShift_q; // Slave frame being shifted out.
   logic [31:0] reply_q; // Frame prepared for the next select.
   logic chanRead_q; // Current read targets a measurement channel.
   logic readPending_q; // Read data arrives this cycle.
   word_t replyData_q; // Read result for the next frame.
   logic [3:0] rollCount_q;
   logic pendFaultA_q, pendFaultB_q, pendFresh_q;
   logic gotoSleep_q; // One-cycle sleep request from the command channel.

   // Command byte decode once eight bits are in.
   wire [7:0] cmdByte = rxShift_q[7:0];
   wire cmdIsRead = cmdByte[`CMD_RW_BIT]; // see R08
   wire [6:0] cmdAddr = cmdByte[7:`CMD_ADDR_LSB]; // see R08
   wire cmdTaken = (bitCount_q == `CMD_BITS) && sckLast_q && !sckSync_q[1] && selected;
   wire cmdIsChan = (cmdAddr >= `CHAN_ADDR_FIRST) && (cmdAddr <= `CHAN_ADDR_LAST);

   // Frame end decode; anything but exactly 32 clocks is dropped.
   wire frameDone = frameEnd && (bitCount_q == `FRAME_BITS); // see R27
   wire [7:0] rxCrcCalc = crcOf(rxShift_q[31:8]); // see R07
   wire crcGood = rxCrcCalc == rxShift_q[7:0]; // see R11
   wire [6:0] frameAddr = rxShift_q[31:25];
   wire frameIsRead = rxShift_q[24];
   wire [15:0] frameData = rxShift_q[23:8]; // see R03
   wire doWrite = frameDone && !frameIsRead && crcGood; // see R09
   wire sleepCmd = doWrite && (frameAddr == `CMD_CHAN_ADDR) &&
      (frameData == `SLEEP_COMMAND); // see R23
   wire [3:0] rollNext = (rollCount_q == `RC_LAST) ? `RC_FIRST : rollCount_q + 4'h1; // see R13

   // Next status byte and reply frame; a write returns no sample, so its
   // fresh bit stays low instead of repeating an older read's flag.
   wire [7:0] statusNext = {rollNext, pendFaultA_q, pendFaultB_q, !crcGood,
      frameIsRead && pendFresh_q}; // see R12 see R16
   wire [15:0] dataNext = frameIsRead ? replyData_q : 16'h0000;
   wire [23:0] payloadNext = {statusNext, dataNext}; // see R04
   wire [7:0] txCrc = crcOf(payloadNext); // see R07

   // Bit counter and receive shift register, sampled on rising edges.
   always_ff @(posedge clock) begin
      if (!reset_n || frameStart) begin
         bitCount_q <= 6'h00;
         rxShift_q <= 32'h0000_0000;
      end else if (sckRise) begin
         if (bitCount_q != 6'h3F) begin
            bitCount_q <= bitCount_q + 6'h01;
         end
         rxShift_q <= {rxShift_q[30:0], mosiSync_q[1]}; // see R27
      end
   end

   // Transmit shift register, changed on falling edges, MSB first.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         txShift_q <= 32'h0000_0000;
      end else if (frameStart) begin
         txShift_q <= reply_q; // see R05
      end else if (sckFall) begin
         txShift_q <= {txShift_q[30:0], 1'b0}; // see R27
      end
   end

   // The data line is driven only while selected.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         misoOut <= 1'b0;
         misoOe <= 1'b0;
      end else begin
         misoOut <= frameStart ? reply_q[31] : (sckFall ? txShift_q[30] : misoOut);
         misoOe <= selected; // see R01
      end
   end

   // Read is launched as soon as the command byte is complete.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         readStrobe <= 1'b0;
         readAddr <= 7'h00;
         chanRead_q <= 1'b0;
         readPending_q <= 1'b0;
      end else begin
         readStrobe <= cmdTaken && cmdIsRead; // see R10
         readPending_q <= readStrobe;
         if (cmdTaken) begin
            readAddr <= cmdAddr; // see R10
            chanRead_q <= cmdIsRead && cmdIsChan;
         end
      end
   end

   // Capture read results; fault bits follow channel reads only.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         replyData_q <= 16'h0000;
         pendFaultA_q <= 1'b0;
         pendFaultB_q <= 1'b0;
         pendFresh_q <= 1'b0;
      end else if (readPending_q) begin
         replyData_q <= readData;
         pendFresh_q <= chanRead_q && readFresh; // see R16
         if (chanRead_q) begin
            pendFaultA_q <= |faultRegA; // see R14 see R15
            pendFaultB_q <= |faultRegB; // see R14 see R15
         end
      end
   end

   // Frame close: counter, status, reply frame and any write.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         rollCount_q <= `RC_RESET; // see R13
         reply_q <= 32'h0000_0000;
         writeStrobe <= 1'b0;
         writeAddr <= 7'h00;
         writeData <= 16'h0000;
         gotoSleep_q <= 1'b0;
      end else begin
         writeStrobe <= doWrite; // see R09
         gotoSleep_q <= sleepCmd; // see R23
         if (frameDone) begin
            rollCount_q <= rollNext; // see R13
            reply_q <= {payloadNext, txCrc}; // see R04 see R05
         end
         if (doWrite) begin
            writeAddr <= frameAddr;
            writeData <= frameData;
         end
      end
   end

   // Standby configuration decode.
   wire [1:0] edgeSel = standbyConfig[`SB_EDGE_LSB +: 2];
   wire timerWake = standbyConfig[`SB_TIMER_BIT];
   wire wakeOutEn = standbyConfig[`SB_WAKEOUT_BIT];
   wire lowPowerEn = timerWake || (edgeSel != 2'h0); // see R17
   wire pinWakeHit = (edgeSel[0] && wakeRise) || (edgeSel[1] && wakeFall); // see R24
   wire [2:0] thrHit; // Per-channel threshold condition.
   wire [2:0] thrOn; // Per-channel threshold compare enabled.
   wire anyThr = |thrOn; // see R20

   // Per-channel threshold compare; reserved code never matches.
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++) begin : gThr
         wire [1:0] sel = standbyConfig[2 * ch +: 2];
         wire above = $signed(measValue[ch]) > $signed(thresholdValue[ch]);
         wire below = $signed(measValue[ch]) < $signed(thresholdValue[ch]);
         assign thrOn[ch] = (sel == `THR_ABOVE) || (sel == `THR_BELOW); // see R25
         assign thrHit[ch] = ((sel == `THR_ABOVE) && above) ||
            ((sel == `THR_BELOW) && below); // see R25
      end
   endgenerate

   // Sleep timer: unit counter of 2 ms and a count of units.
   logic [31:0] unitCount_q;
   logic [8:0] unitsLeft_q;
   logic timerDone_q;
   power_state_t state_q, state_d;
   logic pinWoken_q; // Woken by the master rather than the timer.
   logic wakeLevel_q;
   wire unitTick = unitCount_q == SleepUnitCycles - 1;
   always_ff @(posedge clock) begin
      if (!reset_n || state_q != SLEEPING) begin
         unitCount_q <= 32'h0000_0000;
         unitsLeft_q <= {1'b0, sleepTimeHigh} + 9'h001; // see R26
         timerDone_q <= 1'b0;
      end else begin
         unitCount_q <= unitTick ? 32'h0000_0000 : unitCount_q + 32'h0000_0001;
         if (unitTick) begin
            unitsLeft_q <= unitsLeft_q - 9'h001; // see R26
         end
         timerDone_q <= timerWake && unitTick && (unitsLeft_q == 9'h001); // see R19
      end
   end

   // Phase selection.
   always_comb begin
      state_d = state_q;
      case (state_q)
         RUN_CONT: begin
            if (lowPowerEn && gotoSleep_q) begin
               state_d = SLEEPING; // see R17
            end
         end
         SLEEPING: begin
            if (!lowPowerEn) begin
               state_d = RUN_CONT;
            end else if (timerDone_q || pinWakeHit) begin
               state_d = WAKE_INIT; // see R18 see R19 see R21
            end
         end
         WAKE_INIT: begin
            if (initDone && measStart) begin
               state_d = AWAKE; // see R28
            end
         end
         AWAKE: begin
            if (gotoSleep_q) begin
               state_d = SLEEPING; // see R23
            end else if (!pinWoken_q && anyThr && measValid && !(|thrHit)) begin
               state_d = SLEEPING; // see R20
            end
         end
         default: begin
            state_d = RUN_CONT;
         end
      endcase
   end

   // Phase register and the source of the last wake.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_q <= RUN_CONT;
         pinWoken_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == SLEEPING && state_d == WAKE_INIT) begin
            pinWoken_q <= pinWakeHit && !timerDone_q; // see R21
         end
      end
   end

   // Wake indication: toggled on the first measurement, or, with
   // thresholds armed, on the first measurement that meets one.
   logic toggled_q;
   wire firstMeas = state_q == WAKE_INIT && state_d == AWAKE;
   wire toggleNow = wakeOutEn && timerWake && !pinWoken_q && !toggled_q &&
      (anyThr ? (state_q == AWAKE && measValid && |thrHit) : firstMeas); // see R19 see R20 see R28
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wakeLevel_q <= 1'b0;
         toggled_q <= 1'b0;
      end else begin
         if (toggleNow) begin
            wakeLevel_q <= !wakeLevel_q; // see R19
         end
         toggled_q <= (state_d == AWAKE || state_d == WAKE_INIT) && (toggled_q || toggleNow);
      end
   end

   // The pin is released while asleep if the master may wake us on it.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wakePinOut <= 1'b0;
         wakePinOe <= 1'b0;
         activePhase <= 1'b1;
      end else begin
         wakePinOut <= wakeLevel_q;
         wakePinOe <= wakeOutEn && timerWake && (edgeSel == 2'h0 || state_q != SLEEPING); // see R21 see R22
         activePhase <= state_q != SLEEPING;
      end
   end
endmodule // sensor_spi_slave_lowpower
`default_nettype wire

// File: verification/sensor_spi_lowpower_chk.sv
// Checker of the sensor serial slave and its sleep and wake control.
// Assumes it is bound to the top module and sees only its ports.
`include "sensor_spi_lowpower_map.svh"
`default_nettype none
module sensor_spi_lowpower_chk #(
   parameter int unsigned SleepUnitCycles = 20
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic chipSelectLow,
   input wire logic misoOe,
   input wire logic wakePinOut,
   input wire logic wakePinOe,
   input wire logic [9:0] standbyConfig,
   input wire logic [7:0] sleepTimeHigh,
   input wire logic readStrobe,
   input wire logic writeStrobe,
   input wire logic [6:0] writeAddr,
   input wire sensor_spi_lowpower_pkg::word_t writeData,
   input wire logic initDone,
   input wire logic measStart,
   input wire logic activePhase
);
   import sensor_spi_lowpower_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   logic [31:0] sleepCnt_q; // Cycles spent asleep so far.
   logic measSeen_q; // The active phase has started measuring.
   logic [31:0] sleepMax;
   assign sleepMax = (32'(sleepTimeHigh) + 32'd1) * SleepUnitCycles;
   // Counts the sleep span so its length can be bounded.
   always_ff @(posedge clock) begin
      if (!reset_n || activePhase) sleepCnt_q <= '0;
      else sleepCnt_q <= sleepCnt_q + 32'd1;
   end
   // Notes the first measurement of each active phase.
   always_ff @(posedge clock) begin
      if (!reset_n || !activePhase) measSeen_q <= 1'b0;
      else if (initDone && measStart) measSeen_q <= 1'b1;
   end
   chk_read_in_frame:
      assert property (readStrobe |-> !chipSelectLow ##1 !readStrobe [*8])
      else $error("read strobe misplaced");
   chk_write_after_end:
      assert property (writeStrobe |-> chipSelectLow ##1 !writeStrobe)
      else $error("write strobe misplaced");
   chk_sleep_entry:
      assert property (writeStrobe && writeAddr == `CMD_CHAN_ADDR
         && writeData == `SLEEP_COMMAND && activePhase
         && (standbyConfig[8] || standbyConfig[7:6] != 2'h0) |-> ##[1:4] !activePhase)
      else $error("sleep command not obeyed");
   chk_sleep_max:
      assert property (standbyConfig[8] && !activePhase |-> sleepCnt_q <= sleepMax + 32'd2)
      else $error("sleep too long");
   chk_sleep_min:
      assert property ($rose(activePhase) && standbyConfig[8:6] == 3'h4
         |-> $past(sleepCnt_q) + 32'd2 >= sleepMax)
      else $error("sleep too short");
   chk_wake_drive_off:
      assert property ((!standbyConfig[8] || !standbyConfig[9]) [*2] |-> !wakePinOe)
      else $error("wake pin driven");
   chk_toggle_after_meas:
      assert property ($changed(wakePinOut) |-> measSeen_q)
      else $error("wake toggle before measuring");
   chk_miso_idle:
      assert property (chipSelectLow [*4] |-> !misoOe)
      else $error("data line driven while idle");
   chk_miso_select:
      assert property ($fell(chipSelectLow) |-> ##[1:4] misoOe)
      else $error("data line not driven");
endmodule // sensor_spi_lowpower_chk
`default_nettype wire

// File: verification/spi_master_model.sv
// Serial master model running mode 0 frames against the sensor.
// Assumes a 160 ns serial clock, held low between frames.
`default_nettype none
module spi_master_model (
   output logic spiClk,
   output logic chipSelectLow,
   output logic mosi,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle: not selected, clock low.
   initial begin
      spiClk = 1'b0;
      chipSelectLow = 1'b1;
      mosi = 1'b0;
   end
   // Shifts nBits MSB first and returns the first 32 bits read back.
   task automatic xfer(input logic [31:0] tx, input int nBits, output logic [31:0] rx);
      chipSelectLow = 1'b0;
      for (int i = 0; i < nBits; i++) begin
         mosi = tx[31 - i % 32];
         #80 spiClk = 1'b1;
         if (i < 32) rx[31 - i] = miso;
         #80 spiClk = 1'b0;
      end
      #40 chipSelectLow = 1'b1;
      mosi = ~mosi; // Released data flips so a stale level is never trusted.
      #200;
   endtask
endmodule // spi_master_model
`default_nettype wire

// File: verification/sensor_spi_slave_lowpower_tb.sv
// Self-checking bench of the sensor serial slave and its low-power control.
// Assumes the design, the master model and the checker are compiled first.
`include "sensor_spi_lowpower_map.svh"
`default_nettype none
module sensor_spi_slave_lowpower_tb import sensor_spi_lowpower_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, reset_n, spiClk, chipSelectLow, mosi, misoOut, misoOe, wakePinOut;
   logic wakePinOe, wakeDrive, readStrobe, readFresh, writeStrobe, initDone;
   logic measStart, measValid, activePhase, fa, fb, known;
   logic [9:0] standbyConfig;
   logic [7:0] sleepTimeHigh;
   logic [6:0] readAddr, writeAddr, wrAddr, rdAddr;
   logic [31:0] lastReply; // Reply expected in the next frame.
   word_t faultRegA, faultRegB, readData, writeData, wrData;
   chan_words_t measValue, thresholdValue;
   int nErrors, checkCount, wrCount, rc;
   wire logic miso = misoOe ? misoOut : 1'bz;
   wire logic wakeLine = wakePinOe ? wakePinOut : wakeDrive;
   sensor_spi_slave_lowpower #(.SleepUnitCycles(20)) sensor_spi_slave_lowpower_i (
      .clock, .reset_n, .spiClk, .chipSelectLow, .mosi, .misoOut, .misoOe,
      .wakePinIn(wakeLine), .wakePinOut, .wakePinOe, .standbyConfig, .sleepTimeHigh,
      .faultRegA, .faultRegB, .readStrobe, .readAddr, .readData, .readFresh,
      .writeStrobe, .writeAddr, .writeData, .initDone, .measStart, .measValid,
      .measValue, .thresholdValue, .activePhase
   );
   spi_master_model spi_master_model_i (.spiClk, .chipSelectLow, .mosi, .miso);
   always #2 clock = ~clock;
   // Records each register write and each read address the design issues.
   always @(posedge clock) begin
      if (readStrobe === 1'b1) rdAddr = readAddr;
      if (writeStrobe === 1'b1) begin
         wrCount++;
         wrAddr = writeAddr;
         wrData = writeData;
      end
   end
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      c = `CRC_INIT;
      for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `CRC_POLY : 8'h00);
      return c ^ `CRC_XOR;
   endfunction
   task automatic compare(input string what, input logic [31:0] expv, input logic [31:0] got);
      checkCount++;
      if (got !== expv) begin
         nErrors++;
         $display("ERROR %s expected %h seen %h", what, expv, got);
      end
   endtask
   task automatic giveVerdict();
      $display("checks %0d errors %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // One frame; checks the reply to the previous one and works out the next.
   task automatic frame(input logic rd, input logic [6:0] addr, input word_t d,
         input logic bad, input int nBits);
      logic [23:0] body;
      logic [31:0] rx;
      logic [7:0] st;
      logic chan;
      int w0;
      body = {addr, rd, d};
      w0 = wrCount;
      readData = 16'($urandom);
      readFresh = 1'($urandom);
      faultRegA = 16'($urandom) & 16'h8001;
      faultRegB = 16'($urandom) & 16'h0110;
      rdAddr = 7'h7F; // No read has been launched in this frame yet.
      spi_master_model_i.xfer({body, crc8(body) ^ {7'h00, bad}}, nBits, rx);
      repeat (10) @(negedge clock);
      if (known && nBits >= 32) compare("reply", lastReply, rx);
      compare("writes", wrCount - w0, nBits == 32 && !rd && !bad);
      if (!rd && !bad && nBits == 32) compare("wdata", {addr, d}, {wrAddr, wrData});
      if (rd) compare("raddr", addr, rdAddr);
      // A read starts at its command byte, so even a cut frame samples faults.
      chan = rd && addr <= `CHAN_ADDR_LAST;
      fa = chan ? |faultRegA : fa;
      fb = chan ? |faultRegB : fb;
      if (nBits == 32) begin
         rc = rc == 15 ? 1 : rc + 1;
         st = {4'(rc), fa, fb, bad, chan & readFresh};
         body = {st, rd ? readData : 16'h0000};
         lastReply = {body, crc8(body)};
         known = 1'b1;
      end
   endtask
   // Sends the sensor to sleep, wakes it by timer or pin, then measures.
   task automatic sleepWake(input logic [9:0] cfg, input logic hit, input logic [1:0] pin);
      logic w;
      logic tog;
      standbyConfig = cfg;
      initDone = 1'b0;
      wakeDrive = cfg[9] ? wakePinOut : pin == 2'd2;
      tog = cfg[8] & cfg[9] & pin == 2'd0 & (cfg[5:0] == 6'h00 || hit);
      frame(1'b0, `CMD_CHAN_ADDR, `SLEEP_COMMAND, 1'b0, 32);
      compare("asleep", 0, activePhase);
      w = wakePinOut;
      if (pin != 2'd0) begin
         wakeDrive = ~wakeDrive;
         repeat (4) @(negedge clock);
         wakeDrive = ~wakeDrive;
      end
      for (int t = 0; t < 2000 && activePhase !== 1'b1; t++) @(negedge clock);
      compare("woke", 1, activePhase);
      initDone = 1'b1;
      measValue[0] = (hit ^ cfg[1]) ? 16'h0100 : 16'hFF00;
      @(negedge clock) measStart = 1'b1;
      @(negedge clock) measStart = 1'b0;
      measValid = 1'b1;
      @(negedge clock) measValid = 1'b0;
      repeat (6) @(negedge clock);
      compare("toggle", w ^ tog, wakePinOut);
      compare("active", !(cfg[5:0] != 6'h00 && !hit), activePhase);
   endtask
   initial begin
      int r;
      void'($urandom(22));
      {clock, reset_n, wakeDrive, readFresh, initDone, measStart, measValid} = 0;
      {fa, fb, known, wrCount, rc, nErrors, checkCount} = 0;
      standbyConfig = 10'h000;
      sleepTimeHigh = 8'h07;
      {faultRegA, faultRegB, readData, thresholdValue} = 0;
      measValue = {3{16'($urandom)}};
      repeat (12) @(negedge clock);
      reset_n = 1'b1;
      repeat (6) @(negedge clock);
      frame(1'b1, 7'h00, 16'hFFFF, 1'b0, 32);
      for (int k = 0; k < 26; k++) begin
         r = $urandom_range(0, 9);
         frame(r[0], r[0] ? (r == 5 ? 7'h20 : 7'($urandom_range(0, 2))) : 7'h40 | 7'($urandom),
            16'($urandom), r == 3 || r == 4, r == 8 ? 31 : r == 9 ? 33 : 32);
      end
      sleepTimeHigh = 8'h07;
      sleepWake(10'h040, 1'b0, 2'd1);
      sleepWake(10'h080, 1'b0, 2'd2);
      sleepWake(10'h0C0, 1'b0, 2'd3);
      sleepWake(10'h300, 1'b0, 2'd0);
      sleepWake(10'h301, 1'b1, 2'd0);
      sleepWake(10'h302, 1'b1, 2'd0);
      sleepWake(10'h3C1, 1'b1, 2'd3);
      sleepWake(10'h301, 1'b0, 2'd0);
      giveVerdict();
   end
   // Cuts a hang short.
   initial begin
      #400000;
      nErrors++;
      giveVerdict();
   end
endmodule // sensor_spi_slave_lowpower_tb
bind sensor_spi_slave_lowpower sensor_spi_lowpower_chk #(.SleepUnitCycles(SleepUnitCycles))
   sensor_spi_lowpower_chk_i (.clock, .reset_n, .chipSelectLow, .misoOe, .wakePinOut,
   .wakePinOe, .standbyConfig, .sleepTimeHigh, .readStrobe, .writeStrobe, .writeAddr,
   .writeData, .initDone, .measStart, .activePhase);
`default_nettype wire
